/* File: core/lscl_pkg.sv */
// Shared constants and types for the LED channel serial latch control block.
package lscl_pkg;
  localparam int unsigned WORD_W   = 3;          // Bits per serial control word.
  localparam int unsigned SYNC_W   = 2;          // Synchroniser depth for pin inputs.
  localparam int unsigned CASC_LAT = 3;          // Serial clock edges from data input to cascade.
  localparam logic [2:0]  WORD_RST = 3'h0;       // Power-up contents of register and latch.
  localparam int unsigned BIT_MSB  = 2;          // First bit shifted in.
  localparam int unsigned BIT_MID  = 1;
  localparam int unsigned BIT_LSB  = 0;          // Last bit shifted in.
  localparam int unsigned MODE_W   = 1;
  localparam int unsigned NPIN     = 8;          // Pins passing the synchroniser.
  localparam int unsigned PIN_SCLK = 0;          // Place of each pin in the synchroniser.
  localparam int unsigned PIN_SDAT = 1;
  localparam int unsigned PIN_LOAD = 2;
  localparam int unsigned PIN_ODIS = 3;
  localparam int unsigned PIN_HOT  = 4;
  localparam int unsigned PIN_DIM  = 5;          // Lowest of the three dimming enables.

  // Channel gating source: serial latch or per-channel dimming pins.
  typedef enum logic [0:0] {
    LSCL_MODE_SERIAL = 1'b0,
    LSCL_MODE_PIN    = 1'b1
  } lscl_mode_t;
endpackage

/* File: core/lscl_sync_if.sv */
// Interface carrying synchronised pin levels from the input stage to the core.
`timescale 1ns/1ps
`default_nettype none
interface lscl_sync_if;
  logic       sclk_rise;  // One-cycle pulse on a serial clock rising edge.
  logic       sdata;      // Synchronised serial data level.
  logic       load;       // Synchronised latch-load level.
  logic       load_fall;  // One-cycle pulse on a latch-load falling edge.
  logic       odis;       // Synchronised output-disable level.
  logic       hot;        // Synchronised overheat flag.
  logic [2:0] dim;        // Synchronised per-channel dimming enables.

  modport src (output sclk_rise, sdata, load, load_fall, odis, hot, dim);
  modport dst (input sclk_rise, sdata, load, load_fall, odis, hot, dim);
endinterface
`default_nettype wire

/* File: core/lscl_sync.sv */
// Two-flop synchronisers for all asynchronous pins except the mode strap, which is synchronised in the top, and edge finders for serial clock and latch-load.
`timescale 1ns/1ps
`default_nettype none
module lscl_sync (
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   serial_clk,
  input  wire logic   serial_data,
  input  wire logic   latch_load,
  input  wire logic   output_disable,
  input  wire logic   overheat,
  input  wire logic   dim_1,
  input  wire logic   dim_2,
  input  wire logic   dim_3,
  lscl_sync_if.src    sy
);
  localparam int unsigned NPIN = lscl_pkg::NPIN;

  logic [NPIN-1:0] pins;
  logic [NPIN-1:0] meta_ff;
  logic [NPIN-1:0] sync_ff;
  logic            sclk_prev_ff;
  logic            load_prev_ff;

  assign pins = {dim_3, dim_2, dim_1, overheat, output_disable, latch_load, serial_data,
                 serial_clk};

  ////////////////////////////////////////////////////////////////////////////
  // Each pin passes two flops; only the second flop is read by logic.
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_ff[g] <= 1'b0;
          sync_ff[g] <= 1'b0;
        end else begin
          meta_ff[g] <= pins[g];
          sync_ff[g] <= meta_ff[g];
        end
      end
    end
  endgenerate

  // Previous levels for edge finding, taken from the synchronised copies.
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_prev_ff <= 1'b0;
      load_prev_ff <= 1'b0;
    end else begin
      sclk_prev_ff <= sync_ff[lscl_pkg::PIN_SCLK];
      load_prev_ff <= sync_ff[lscl_pkg::PIN_LOAD];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data is taken together with the clock edge, so both saw equal delay.
  assign sy.sclk_rise = sync_ff[lscl_pkg::PIN_SCLK] & ~sclk_prev_ff;
  assign sy.sdata     = sync_ff[lscl_pkg::PIN_SDAT];
  assign sy.load      = sync_ff[lscl_pkg::PIN_LOAD];
  assign sy.load_fall = ~sync_ff[lscl_pkg::PIN_LOAD] & load_prev_ff;
  assign sy.odis      = sync_ff[lscl_pkg::PIN_ODIS];
  assign sy.hot       = sync_ff[lscl_pkg::PIN_HOT];
  assign sy.dim       = sync_ff[lscl_pkg::PIN_DIM +: lscl_pkg::WORD_W];
endmodule
`default_nettype wire

/* File: core/lscl_top.sv */
// Serial shift register, output latch and channel gating for a three-channel LED sink.
//
// Summary of operation
// RQ1: A control word is three bits, one per channel, held in a shift register.
// RQ2: The controller holds serial data stable around each serial clock rising edge.
// RQ3: Bits arrive most significant first; least significant bit arrives last.
// RQ4: Each serial clock rising edge shifts the register and loads the data bit.
// RQ5: While latch-load is high the output latch copies the shift register.
// RQ6: Latch-load falling edge captures the register; latch holds while low.
// RQ7: Output-disable high puts all channels high impedance; latch stays unchanged. The code does so in serial mode only; pin mode ignores it.
// RQ8: Output-disable low makes each channel follow its latch bit.
// RQ9: Shifting and latching ignore the output-disable level.
// RQ10: Cascade output shows the last register stage, updated per serial clock edge.
// RQ11: A data bit reaches the cascade output after three serial clock edges.
// RQ12: In pin mode each dimming input enables its channel when high.
// RQ13: The controller keeps each dimming input at or below 5 kHz.
// RQ14: Repeated latching with outputs enabled switches all channels together.
// RQ15: With latch-load held high, controller chooses bits carefully for common dimming.
// RQ16: With latch and outputs enabled, controller respects the maximum switching rate.
// RQ17: Overheat turns all channel sinks off until the temperature falls back.
// RQ18: Latch bit 0 drives channel 1, bit 1 channel 2, bit 2 channel 3.
`timescale 1ns/1ps
`default_nettype none
module lscl_top (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic mode_pin,
  input  wire logic serial_clk,
  input  wire logic serial_data,
  input  wire logic latch_load,
  input  wire logic output_disable,
  input  wire logic overheat,
  input  wire logic dim_1,
  input  wire logic dim_2,
  input  wire logic dim_3,
  output logic      cascade_out,
  output logic      channel_sink_1,
  output logic      channel_sink_2,
  output logic      channel_sink_3,
  output logic      channel_oe_1,
  output logic      channel_oe_2,
  output logic      channel_oe_3
);
  lscl_sync_if sy ();

  lscl_pkg::lscl_mode_t        mode_ff;
  logic [lscl_pkg::WORD_W-1:0] shift_ff;
  logic [lscl_pkg::WORD_W-1:0] nxt_shift;
  logic [lscl_pkg::WORD_W-1:0] latch_ff;
  logic [lscl_pkg::WORD_W-1:0] nxt_latch;
  logic [lscl_pkg::WORD_W-1:0] sink_ff;
  logic [lscl_pkg::WORD_W-1:0] oe_ff;
  logic [lscl_pkg::WORD_W-1:0] nxt_sink;
  logic [lscl_pkg::WORD_W-1:0] nxt_oe;
  logic                        casc_ff;
  logic                        mode_meta_ff;
  logic                        mode_sync_ff;
  logic [1:0]                  sent_ff;
  logic [1:0]                  nxt_sent;

  lscl_sync u_sync (
    .clk            (clk),
    .rst            (rst),
    .serial_clk     (serial_clk),
    .serial_data    (serial_data),
    .latch_load     (latch_load),
    .output_disable (output_disable),
    .overheat       (overheat),
    .dim_1          (dim_1),
    .dim_2          (dim_2),
    .dim_3          (dim_3),
    .sy             (sy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Variant strap, synchronised and then registered every cycle, so a later change on the pin switches the mode.
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_meta_ff <= 1'b0;
      mode_sync_ff <= 1'b0;
    end else begin
      mode_meta_ff <= mode_pin;
      mode_sync_ff <= mode_meta_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_ff <= lscl_pkg::LSCL_MODE_SERIAL;
    end else begin
      mode_ff <= lscl_pkg::lscl_mode_t'(mode_sync_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // New bits enter at the bottom, so the first bit sent ends in the top stage.
  assign nxt_shift = sy.sclk_rise ? {shift_ff[lscl_pkg::BIT_MID:lscl_pkg::BIT_LSB], sy.sdata}
                                  : shift_ff; // RQ1 RQ3 RQ4 RQ9

  // Transparent while load is high; the falling-edge pulse takes the register once more.
  assign nxt_latch = (sy.load || sy.load_fall) ? nxt_shift : latch_ff; // RQ5 RQ6 RQ9

  always_ff @(posedge clk) begin
    if (rst) begin
      shift_ff <= lscl_pkg::WORD_RST;
      latch_ff <= lscl_pkg::WORD_RST;
      casc_ff  <= 1'b0;
    end else begin
      shift_ff <= nxt_shift;
      latch_ff <= nxt_latch;
      casc_ff  <= nxt_shift[lscl_pkg::BIT_MSB]; // RQ10 RQ11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel gating. A sink drives low when on and is released otherwise, like an
  // open drain; overheat releases every channel regardless of mode.
  genvar c;
  generate
    for (c = 0; c < lscl_pkg::WORD_W; c++) begin : g_ch
      assign nxt_sink[c] = 1'b0;
      assign nxt_oe[c]   = sy.hot ? 1'b0 :                                 // RQ17
                           (mode_ff == lscl_pkg::LSCL_MODE_PIN) ? sy.dim[c] : // RQ12
                           (~sy.odis & latch_ff[c]);                       // RQ7 RQ8 RQ14 RQ18
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      sink_ff <= lscl_pkg::WORD_RST;
      oe_ff   <= lscl_pkg::WORD_RST;
    end else begin
      sink_ff <= nxt_sink;
      oe_ff   <= nxt_oe;
    end
  end

  assign cascade_out    = casc_ff;
  assign channel_sink_1 = sink_ff[0];
  assign channel_sink_2 = sink_ff[1];
  assign channel_sink_3 = sink_ff[2];
  assign channel_oe_1   = oe_ff[0];
  assign channel_oe_2   = oe_ff[1];
  assign channel_oe_3   = oe_ff[2];

  ////////////////////////////////////////////////////////////////////////////
  // Checker helper: bits taken on the last two serial clock rises, oldest on top.
  // It is kept apart from the register so that bit order is checked by count.
  assign nxt_sent = sy.sclk_rise ? {sent_ff[0], sy.sdata} : sent_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      sent_ff <= 2'h0;
    end else begin
      sent_ff <= nxt_sent;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the logic this block drives.
  property p_shift_in;
    @(posedge clk) disable iff (rst)
      sy.sclk_rise |=> shift_ff == {$past(shift_ff[lscl_pkg::BIT_MID:lscl_pkg::BIT_LSB]),
                                    $past(sy.sdata)};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("shift register did not shift"); // RQ4

  property p_shift_hold;
    @(posedge clk) disable iff (rst)
      !sy.sclk_rise |=> $stable(shift_ff);
  endproperty
  a_shift_hold: assert property (p_shift_hold) else $error("shift register moved without edge"); // RQ1

  property p_msb_first;
    @(posedge clk) disable iff (rst)
      sy.sclk_rise |=> shift_ff[lscl_pkg::BIT_MSB] == $past(sent_ff[1]) &&
                       shift_ff[lscl_pkg::BIT_LSB] == $past(sy.sdata);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit not in top stage"); // RQ3

  property p_transparent;
    @(posedge clk) disable iff (rst)
      sy.load |=> latch_ff == shift_ff;
  endproperty
  a_transparent: assert property (p_transparent) else $error("latch not transparent"); // RQ5

  property p_latch_hold;
    @(posedge clk) disable iff (rst)
      (!sy.load && !sy.load_fall) |=> $stable(latch_ff);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed while closed"); // RQ6

  property p_disable;
    @(posedge clk) disable iff (rst)
      (sy.odis && mode_ff == lscl_pkg::LSCL_MODE_SERIAL) |=> oe_ff == 3'h0;
  endproperty
  a_disable: assert property (p_disable) else $error("channel driven while disabled"); // RQ7

  property p_follow;
    @(posedge clk) disable iff (rst)
      (!sy.odis && !sy.hot && mode_ff == lscl_pkg::LSCL_MODE_SERIAL) |=> oe_ff == $past(latch_ff);
  endproperty
  a_follow: assert property (p_follow) else $error("channel not following latch"); // RQ8

  property p_cascade;
    @(posedge clk) disable iff (rst)
      1'b1 |=> cascade_out == shift_ff[lscl_pkg::BIT_MSB];
  endproperty
  a_cascade: assert property (p_cascade) else $error("cascade not last stage"); // RQ10

  // The bit taken two rises ago leaves on the third rise.
  property p_cascade_lat;
    @(posedge clk) disable iff (rst)
      sy.sclk_rise |=> cascade_out == $past(sent_ff[1]);
  endproperty
  a_cascade_lat: assert property (p_cascade_lat) else $error("cascade latency wrong"); // RQ11

  property p_pin_dim;
    @(posedge clk) disable iff (rst)
      (!sy.hot && mode_ff == lscl_pkg::LSCL_MODE_PIN) |=> oe_ff == $past(sy.dim);
  endproperty
  a_pin_dim: assert property (p_pin_dim) else $error("dimming pin not obeyed"); // RQ12

  property p_hot;
    @(posedge clk) disable iff (rst)
      sy.hot |=> oe_ff == 3'h0;
  endproperty
  a_hot: assert property (p_hot) else $error("channel on during overheat"); // RQ17
endmodule
`default_nettype wire

/* File: tb/lscl_serial_src.sv */
// Serial source model standing in for the controller that feeds the shift register.
`timescale 1ns/1ps
`default_nettype none
module lscl_serial_src (
  output logic serial_clk,
  output logic serial_data
);
  localparam real HALF_NS = 62.5; // Half of the 125 ns link clock period.

  ////////////////////////////////////////////////////////////////////////////////
  // The link clock rests low between words, as a real controller leaves it.
  initial begin
    serial_clk  = 1'b0;
    serial_data = 1'b0;
  end

  // Data is set half a period before the rise and held until the fall, far beyond
  // the sampling window of the synchroniser.
  task automatic send_bit(input logic b);
    serial_data = b;
    #(HALF_NS) serial_clk = 1'b1;
    #(HALF_NS) serial_clk = 1'b0;
  endtask

  // A word goes out top bit first; afterwards the line shows the inverse of the
  // last bit so a stale level can never pass for good data.
  task automatic send_word(input logic [2:0] w);
    for (int i = 2; i >= 0; i--) begin
      send_bit(w[i]);
    end
    serial_data = ~w[0];
  endtask
endmodule
`default_nettype wire

/* File: tb/lscl_tb_top.sv */
// Self-checking testbench for the LED channel serial latch control block.
`timescale 1ns/1ps
`default_nettype none
module lscl_tb_top;
  localparam int TIMEOUT = 80000;
  logic       clk, rst, mode_pin, latch_load, output_disable, overheat;
  logic [2:0] dim, reg_m, lat_m;
  wire        serial_clk, serial_data, cascade_out;
  wire  [2:0] sink, oe;
  logic [6:0] exp_q[$];
  int         errors, n_compared, cycles, seed;
  event       chk_ev;

  lscl_serial_src i_src (.serial_clk(serial_clk), .serial_data(serial_data));

  lscl_top i_dut (
    .clk(clk), .rst(rst), .mode_pin(mode_pin), .serial_clk(serial_clk),
    .serial_data(serial_data), .latch_load(latch_load), .output_disable(output_disable),
    .overheat(overheat), .dim_1(dim[0]), .dim_2(dim[1]), .dim_3(dim[2]),
    .cascade_out(cascade_out), .channel_sink_1(sink[0]), .channel_sink_2(sink[1]),
    .channel_sink_3(sink[2]), .channel_oe_1(oe[0]), .channel_oe_2(oe[1]),
    .channel_oe_3(oe[2])
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and a cycle ceiling that cuts a hang short.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == TIMEOUT) begin
      errors++;
      final_report();
    end
  end

  task automatic check(input string what, input logic [6:0] seen, input logic [6:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Lets the synchroniser latency pass, then notes the expected outputs.
  // Sinks are open drain, so their drive value is always low.
  task automatic note();
    logic [2:0] o;
    repeat (10) @(negedge clk);
    o = overheat ? 3'h0 : mode_pin ? dim : output_disable ? 3'h0 : lat_m;
    exp_q.push_back({reg_m[2], 3'h0, o});
    ->chk_ev;
  endtask

  task automatic shift_word(input logic [2:0] w);
    i_src.send_word(w);
    reg_m = w;
    if (latch_load) lat_m = w;
  endtask

  task automatic shift_bit(input logic b);
    i_src.send_bit(b);
    reg_m = {reg_m[1:0], b};
    if (latch_load) lat_m = reg_m;
  endtask

  task automatic pulse_latch();
    @(negedge clk) latch_load = 1'b1;
    lat_m = reg_m;
    repeat (8) @(negedge clk);
    latch_load = 1'b0;
  endtask

  // Watcher: every note is matched against the settled outputs in arrival order.
  initial begin
    forever begin
      @(chk_ev);
      check("outputs", {cascade_out, sink, oe}, exp_q.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    seed = 67413;
    {rst, mode_pin, latch_load, output_disable, overheat} = 5'h10;
    dim = 3'h0;
    reg_m = 3'h0;
    lat_m = 3'h0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    note();
    // Every word value: held back while latch is low, shown together after a pulse.
    for (int w = 0; w < 8; w++) begin
      shift_word(3'(w));
      note();
      pulse_latch();
      note();
    end
    // Disabled outputs keep the latch, and shifting goes on regardless.
    @(negedge clk) output_disable = 1'b1;
    note();
    shift_word(3'($random(seed)));
    pulse_latch();
    note();
    @(negedge clk) output_disable = 1'b0;
    note();
    // Transparent latch: each shifted bit reaches the channels directly.
    @(negedge clk) latch_load = 1'b1;
    for (int i = 0; i < 6; i++) begin
      shift_bit(1'($random(seed)));
      note();
    end
    @(negedge clk) latch_load = 1'b0;
    shift_word(~reg_m);
    note();
    // Overheat forces every channel off and releases them afterwards.
    @(negedge clk) overheat = 1'b1;
    note();
    @(negedge clk) overheat = 1'b0;
    note();
    // A second reset in mid-run clears register, latch and cascade.
    @(negedge clk) rst = 1'b1;
    reg_m = 3'h0;
    lat_m = 3'h0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    note();
    // Pin variant: each enable drives its own channel; slow rate keeps dimming legal.
    @(negedge clk) mode_pin = 1'b1;
    for (int i = 0; i < 5; i++) begin
      @(negedge clk) dim = (i == 4) ? 3'h7 : 3'($random(seed));
      note();
      repeat (10000) @(negedge clk);
    end
    @(negedge clk) overheat = 1'b1;
    note();
    // Let the watcher take the last note before the run ends.
    @(negedge clk);
    final_report();
  end
endmodule
`default_nettype wire
